// File: src/cas_pkg.sv
package cas_pkg;
	// address and data widths
	localparam int AW = 16;
	localparam int DW = 8;
	// reset vector pair
	localparam logic [15:0] RST_VEC_HI = 16'hFFFE;
	localparam logic [15:0] RST_VEC_LO = 16'hFFFF;
	// default soft trap vector, free to change
	localparam logic [15:0] TRAP_VEC_DEF = 16'hFFFC;
	// interrupt mask position in condition_flags
	localparam int FLAG_I_BIT = 3;
	// address step for post increment and byte walks
	localparam logic [15:0] ADDR_STEP = 16'h0001;
	// last push index (five bytes) and last queue fill index (three bytes)
	localparam logic [2:0] PUSH_LAST = 3'h4;
	localparam logic [1:0] FILL_LAST = 2'h2;
	// synchroniser depth for pins
	localparam int SYNC_STAGES = 3;
	// operand addressing modes
	typedef enum logic [2:0] {
		MODE_ABS      = 3'b000, // absolute_mode
		MODE_PTR      = 3'b001, // pointer_mode
		MODE_PTR_PI   = 3'b010, // pointer_postinc_mode
		MODE_OFF8     = 3'b011, // pointer_off8_mode
		MODE_OFF8_PI  = 3'b100, // pointer_off8_postinc_mode
		MODE_OFF16    = 3'b101, // pointer_off16_mode
		MODE_SP8      = 3'b110, // stack_off8_mode
		MODE_SP16     = 3'b111  // stack_off16_mode
	} cas_mode_e;
	// requests from instruction control
	typedef enum logic [2:0] {
		OP_EA   = 3'b000, // operand address
		OP_TRAP = 3'b001, // soft_trap_op
		OP_WAIT = 3'b010, // wait instruction
		OP_STOP = 3'b011, // stop instruction
		OP_HALT = 3'b100  // debug_halt_op
	} cas_op_e;
	// sequencer states
	typedef enum logic [3:0] {
		S_RST    = 4'b0000,
		S_VH     = 4'b0001,
		S_VL     = 4'b0010,
		S_FREE   = 4'b0011,
		S_FILL   = 4'b0100,
		S_IDLE   = 4'b0101,
		S_EXT_HI = 4'b0110,
		S_EXT_LO = 4'b0111,
		S_POST   = 4'b1000,
		S_PUSH   = 4'b1001,
		S_WAIT   = 4'b1010,
		S_STOP   = 4'b1011,
		S_BDM    = 4'b1100
	} cas_state_e;
	// modulo 2^16 address addition
	function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
		add16 = a + b;
	endfunction : add16
endpackage : cas_pkg

// File: src/cas_sync.sv
`timescale 1ns/1ps
module cas_sync #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_reset,
	// raw pins and filtered levels
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);
	import cas_pkg::*;
	logic [W-1:0] s1_ff; // first stage, read only by s2
	logic [W-1:0] s2_ff; // second stage
	logic [W-1:0] s3_ff; // third stage
	logic [W-1:0] lvl_ff; // accepted level
	// three stage chain, idle pins read high
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
		end else begin
			s1_ff <= i_pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	// a change counts once stages two and three agree
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			lvl_ff <= '1;
		end else begin
			for (int k = 0; k < W; k++) begin
				if (s2_ff[k] == s3_ff[k]) begin
					lvl_ff[k] <= s3_ff[k];
				end
			end
		end
	end
	assign o_level = lvl_ff;
endmodule : cas_sync

// File: src/cas_agen.sv
`timescale 1ns/1ps
module cas_agen (
	// operand mode and bases
	input  wire cas_pkg::cas_mode_e i_mode,
	input  wire logic [15:0]        i_index,
	input  wire logic [15:0]        i_sp,
	input  wire logic [15:0]        i_off,
	// results
	output logic      [15:0]        o_ea,
	output logic      [15:0]        o_index_inc,
	output logic                    o_postinc
);
	import cas_pkg::*;
	// effective address per mode, all sums wrap at 64K
	always_comb begin
		case (i_mode)
			MODE_PTR, MODE_PTR_PI: o_ea = i_index;
			MODE_OFF8, MODE_OFF8_PI: o_ea = add16(i_index, {8'h00, i_off[7:0]});
			MODE_OFF16: o_ea = add16(i_index, i_off);
			MODE_SP8: o_ea = add16(i_sp, {8'h00, i_off[7:0]});
			MODE_SP16: o_ea = add16(i_sp, i_off);
			default: o_ea = i_off; // absolute handled by bus reads
		endcase
	end
	// post increment candidates
	assign o_index_inc = add16(i_index, ADDR_STEP);
	assign o_postinc = (i_mode == MODE_PTR_PI) || (i_mode == MODE_OFF8_PI);
endmodule : cas_agen

// File: src/cas_seq.sv
`timescale 1ns/1ps
module cas_seq #(
	parameter logic [15:0] TRAP_VEC = cas_pkg::TRAP_VEC_DEF
) (
	// clock and reset
	input  wire logic               i_core_clk,
	input  wire logic               i_reset,
	// reset sources
	input  wire logic               i_wdog_reset,
	input  wire logic               i_reset_pin_n,
	input  wire logic               i_src_det_done,
	input  wire logic               i_debug_pin,
	// instruction control requests
	input  wire logic               i_op_valid,
	input  wire cas_pkg::cas_op_e   i_op,
	input  wire cas_pkg::cas_mode_e i_mode,
	input  wire logic [15:0]        i_off,
	input  wire logic               i_insn_boundary,
	input  wire logic               i_operand_done,
	// cpu register values
	input  wire logic [15:0]        i_pc,
	input  wire logic [15:0]        i_index,
	input  wire logic [15:0]        i_sp,
	input  wire logic [7:0]         i_acc,
	input  wire logic [7:0]         i_flags,
	// interrupt sources
	input  wire logic               i_irq,
	input  wire logic [15:0]        i_irq_vec,
	// debug module
	input  wire logic               i_debug_enable_bit,
	input  wire logic               i_dbg_enter,
	input  wire logic               i_dbg_resume,
	input  wire logic               i_single_step_cmd,
	input  wire logic               i_tag_resume_cmd,
	// clock control
	input  wire logic               i_stop_min_clk,
	// system bus
	input  wire logic [7:0]         i_bus_rdata,
	output logic      [15:0]        o_bus_addr,
	output logic                    o_bus_rd,
	output logic                    o_bus_wr,
	output logic      [7:0]         o_bus_wdata,
	// register write back
	output logic      [15:0]        o_ea,
	output logic                    o_ea_valid,
	output logic      [15:0]        o_index_new,
	output logic                    o_index_we,
	output logic      [15:0]        o_sp_new,
	output logic                    o_sp_we,
	output logic      [7:0]         o_flags_new,
	output logic                    o_flags_we,
	output logic      [15:0]        o_pc_new,
	output logic                    o_pc_we,
	output logic      [7:0]         o_queue_byte,
	output logic                    o_queue_we,
	// status and clocks
	output logic                    o_busy,
	output logic                    o_irq_ack,
	output logic                    o_cpu_clk_run,
	output logic                    o_osc_keep,
	output logic                    o_min_clk_run,
	output logic                    o_bdm_active
);
	import cas_pkg::*;
	cas_state_e  state_ff;    // sequencer state
	logic [15:0] addr_ff;     // bus address
	logic        rd_ff;       // bus read strobe
	logic        wr_ff;       // bus write strobe
	logic [7:0]  wdata_ff;    // bus write data
	logic [15:0] vec_ptr_ff;  // vector location
	logic [15:0] vec_ff;      // fetched vector
	logic [2:0]  pcnt_ff;     // push index
	logic [1:0]  qcnt_ff;     // queue fill index
	logic [15:0] ea_ff;       // effective address
	logic        ea_v_ff;     // address strobe
	logic [15:0] idx_ff;      // new index pair
	logic        idx_we_ff;   // index write strobe
	logic [15:0] sp_ff;       // new stack pointer
	logic        sp_we_ff;    // sp write strobe
	logic [7:0]  flg_ff;      // new flags
	logic        flg_we_ff;   // flags write strobe
	logic        pc_we_ff;    // pc write strobe
	logic [7:0]  qb_ff;       // queue byte
	logic        qwe_ff;      // queue write strobe
	logic        ack_ff;      // interrupt taken
	logic        bdm_rst_ff;  // reset into background
	logic [1:0]  pins;        // filtered pins
	logic [15:0] ea_calc;     // address from generator
	logic [15:0] idx_inc;     // index plus one
	logic        postinc;     // mode increments index
	logic        abort;       // any reset event
	logic        take_irq;    // interrupt accepted
	logic        take_op;     // request accepted
	logic        dbg_exit;    // resume command

	// pin filtering
	cas_sync #(.W(2)) u_sync (
		.i_core_clk(i_core_clk),
		.i_reset   (i_reset),
		.i_pin     ({i_debug_pin, i_reset_pin_n}),
		.o_level   (pins)
	);
	// address arithmetic
	cas_agen u_agen (
		.i_mode     (i_mode),
		.i_index    (i_index),
		.i_sp       (i_sp),
		.i_off      (i_off),
		.o_ea       (ea_calc),
		.o_index_inc(idx_inc),
		.o_postinc  (postinc)
	);

	// byte to push for a given slot
	function automatic logic [7:0] push_byte(input logic [2:0] n, input logic [15:0] pc,
		input logic [15:0] ix, input logic [7:0] a, input logic [7:0] f);
		case (n)
			3'h0: push_byte = pc[7:0];
			3'h1: push_byte = pc[15:8];
			3'h2: push_byte = ix[7:0];
			3'h3: push_byte = a;
			default: push_byte = f;
		endcase
	endfunction : push_byte

	// event decode
	assign abort = i_wdog_reset || !pins[0];
	assign take_irq = (state_ff == S_IDLE) && i_insn_boundary && i_irq
		&& !i_flags[FLAG_I_BIT];
	assign take_op = (state_ff == S_IDLE) && i_op_valid && !take_irq;
	assign dbg_exit = i_dbg_resume || i_single_step_cmd || i_tag_resume_cmd;

	// main sequence and bus strobes
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_ff <= S_RST;
			addr_ff <= 16'h0000;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			wdata_ff <= 8'h00;
			vec_ptr_ff <= RST_VEC_HI;
			pcnt_ff <= 3'h0;
			qcnt_ff <= 2'h0;
		end else if (abort) begin
			state_ff <= S_RST;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
		end else begin
			case (state_ff)
				S_RST: begin
					if (i_src_det_done) begin
						if (!pins[1]) begin
							state_ff <= S_BDM;
						end else begin
							state_ff <= S_VH;
							vec_ptr_ff <= RST_VEC_HI;
							addr_ff <= RST_VEC_HI;
							rd_ff <= 1'b1;
						end
					end
				end
				S_VH: begin
					state_ff <= S_VL;
					addr_ff <= add16(vec_ptr_ff, ADDR_STEP);
				end
				S_VL: begin
					state_ff <= S_FREE;
					rd_ff <= 1'b0;
				end
				S_FREE: begin
					state_ff <= S_FILL;
					addr_ff <= vec_ff;
					rd_ff <= 1'b1;
					qcnt_ff <= 2'h0;
				end
				S_FILL: begin
					qcnt_ff <= qcnt_ff + 2'h1;
					addr_ff <= add16(addr_ff, ADDR_STEP);
					if (qcnt_ff == FILL_LAST) begin
						state_ff <= S_IDLE;
						rd_ff <= 1'b0;
					end
				end
				S_IDLE: begin
					if (take_irq) begin
						state_ff <= S_PUSH;
						vec_ptr_ff <= i_irq_vec;
						addr_ff <= i_sp;
						wr_ff <= 1'b1;
						wdata_ff <= push_byte(3'h0, i_pc, i_index, i_acc, i_flags);
						pcnt_ff <= 3'h0;
					end else if (take_op) begin
						case (i_op)
							OP_EA: begin
								if (i_mode == MODE_ABS) begin
									state_ff <= S_EXT_HI;
									addr_ff <= i_pc;
									rd_ff <= 1'b1;
								end else if (postinc) begin
									state_ff <= S_POST;
								end
							end
							OP_TRAP: begin
								state_ff <= S_PUSH;
								vec_ptr_ff <= TRAP_VEC;
								addr_ff <= i_sp;
								wr_ff <= 1'b1;
								wdata_ff <= push_byte(3'h0, i_pc, i_index, i_acc, i_flags);
								pcnt_ff <= 3'h0;
							end
							OP_WAIT: state_ff <= S_WAIT;
							OP_STOP: state_ff <= S_STOP;
							default: state_ff <= S_BDM;
						endcase
					end
				end
				S_EXT_HI: begin
					state_ff <= S_EXT_LO;
					addr_ff <= add16(addr_ff, ADDR_STEP);
				end
				S_EXT_LO: begin
					state_ff <= S_IDLE;
					rd_ff <= 1'b0;
				end
				S_POST: begin
					if (i_operand_done) begin
						state_ff <= S_IDLE;
					end
				end
				S_PUSH: begin
					if (pcnt_ff == PUSH_LAST) begin
						state_ff <= S_VH;
						wr_ff <= 1'b0;
						addr_ff <= vec_ptr_ff;
						rd_ff <= 1'b1;
					end else begin
						pcnt_ff <= pcnt_ff + 3'h1;
						addr_ff <= add16(addr_ff, 16'hFFFF);
						wdata_ff <= push_byte(pcnt_ff + 3'h1, i_pc, i_index, i_acc, i_flags);
					end
				end
				S_WAIT: begin
					if (i_dbg_enter) begin
						state_ff <= S_BDM;
					end else if (i_irq) begin
						state_ff <= S_IDLE;
					end
				end
				S_STOP: begin
					if (i_dbg_enter && o_osc_keep) begin
						state_ff <= S_BDM;
					end else if (i_irq) begin
						state_ff <= S_IDLE;
					end
				end
				default: begin
					if (dbg_exit) begin
						state_ff <= S_IDLE;
					end
				end
			endcase
		end
	end

	// vector and queue capture
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			vec_ff <= 16'h0000;
			qb_ff <= 8'h00;
			qwe_ff <= 1'b0;
			pc_we_ff <= 1'b0;
		end else begin
			qwe_ff <= (state_ff == S_FILL) && !abort;
			pc_we_ff <= (state_ff == S_FILL) && (qcnt_ff == FILL_LAST) && !abort;
			if (state_ff == S_VH) begin
				vec_ff[15:8] <= i_bus_rdata;
			end
			if (state_ff == S_VL) begin
				vec_ff[7:0] <= i_bus_rdata;
			end
			if (state_ff == S_FILL) begin
				qb_ff <= i_bus_rdata;
			end
		end
	end

	// operand address and index write back
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ea_ff <= 16'h0000;
			ea_v_ff <= 1'b0;
			idx_ff <= 16'h0000;
			idx_we_ff <= 1'b0;
		end else begin
			ea_v_ff <= 1'b0;
			idx_we_ff <= 1'b0;
			if (take_op && (i_op == OP_EA) && (i_mode != MODE_ABS) && !abort) begin
				ea_ff <= ea_calc;
				ea_v_ff <= 1'b1;
			end
			if (state_ff == S_EXT_HI) begin
				ea_ff[15:8] <= i_bus_rdata;
			end
			if ((state_ff == S_EXT_LO) && !abort) begin
				ea_ff[7:0] <= i_bus_rdata;
				ea_v_ff <= 1'b1;
			end
			if ((state_ff == S_POST) && i_operand_done && !abort) begin
				idx_ff <= idx_inc;
				idx_we_ff <= 1'b1;
			end
		end
	end

	// flags and stack pointer write back
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			flg_ff <= 8'h00;
			flg_we_ff <= 1'b0;
			sp_ff <= 16'h0000;
			sp_we_ff <= 1'b0;
			ack_ff <= 1'b0;
		end else begin
			flg_we_ff <= 1'b0;
			sp_we_ff <= 1'b0;
			ack_ff <= take_irq && !abort;
			if ((state_ff == S_PUSH) && (pcnt_ff == PUSH_LAST) && !abort) begin
				flg_ff <= i_flags | (8'h01 << FLAG_I_BIT);
				flg_we_ff <= 1'b1;
				sp_ff <= add16(addr_ff, 16'hFFFF);
				sp_we_ff <= 1'b1;
			end else if (take_op && (i_op == OP_WAIT) && !abort) begin
				flg_ff <= i_flags & ~(8'h01 << FLAG_I_BIT);
				flg_we_ff <= 1'b1;
			end
		end
	end

	// reset into background is caught after the release
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			bdm_rst_ff <= 1'b0;
		end else if ((state_ff == S_RST) && i_src_det_done && !abort) begin
			bdm_rst_ff <= !pins[1];
		end
	end

	// outputs
	assign o_bus_addr = addr_ff;
	assign o_bus_rd = rd_ff;
	assign o_bus_wr = wr_ff;
	assign o_bus_wdata = wdata_ff;
	assign o_ea = ea_ff;
	assign o_ea_valid = ea_v_ff;
	assign o_index_new = idx_ff;
	assign o_index_we = idx_we_ff;
	assign o_sp_new = sp_ff;
	assign o_sp_we = sp_we_ff;
	assign o_flags_new = flg_ff;
	assign o_flags_we = flg_we_ff;
	assign o_pc_new = vec_ff;
	assign o_pc_we = pc_we_ff;
	assign o_queue_byte = qb_ff;
	assign o_queue_we = qwe_ff;
	assign o_irq_ack = ack_ff;
	assign o_busy = (state_ff != S_IDLE);
	assign o_bdm_active = (state_ff == S_BDM);
	assign o_cpu_clk_run = (state_ff != S_WAIT) && (state_ff != S_STOP);
	assign o_osc_keep = i_debug_enable_bit || bdm_rst_ff;
	assign o_min_clk_run = (state_ff == S_STOP) && i_stop_min_clk;

	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	sequence s_rst_done;
		(state_ff == S_RST) ##1 (state_ff == S_VH);
	endsequence
	sequence s_push_start;
		$rose(wr_ff);
	endsequence
	a_reset_abort: assert property (abort |=> state_ff == S_RST)
		else $error("reset event did not abort");
	a_reset_vectors: assert property (s_rst_done |-> (addr_ff == RST_VEC_HI) && rd_ff
		##1 (addr_ff == RST_VEC_LO) && rd_ff)
		else $error("reset vector addresses wrong");
	a_reset_six: assert property (disable iff (i_reset || abort)
		s_rst_done |-> ##5 (state_ff == S_FILL) && (qcnt_ff == FILL_LAST) ##1 (state_ff == S_IDLE))
		else $error("reset sequence not six cycles");
	a_push_order: assert property (disable iff (i_reset || abort) s_push_start
		|-> wdata_ff == i_pc[7:0] ##1 wdata_ff == i_pc[15:8] ##1 wdata_ff == i_index[7:0]
		##1 wdata_ff == i_acc ##1 wdata_ff == i_flags)
		else $error("stacking order wrong");
	a_push_five: assert property (disable iff (i_reset || abort) s_push_start |-> wr_ff[*5] ##1 !wr_ff)
		else $error("push count not five");
	a_mask_set: assert property ((state_ff == S_PUSH) && (pcnt_ff == PUSH_LAST) && !abort
		|=> flg_we_ff && flg_ff[FLAG_I_BIT] ##1 (state_ff == S_VL))
		else $error("mask not set after stacking");
	a_vec_held: assert property (take_irq && !abort |=> (vec_ptr_ff == $past(i_irq_vec)))
		else $error("vector not latched at start");
	a_wait_clear: assert property (take_op && (i_op == OP_WAIT) && !abort
		|=> flg_we_ff && !flg_ff[FLAG_I_BIT] && !o_cpu_clk_run)
		else $error("wait did not clear mask");
	a_off16_sum: assert property (take_op && (i_op == OP_EA) && (i_mode == MODE_OFF16) && !abort
		|=> ea_v_ff && (ea_ff == add16($past(i_index), $past(i_off))))
		else $error("offset sum wrong");
	a_post_inc: assert property ((state_ff == S_POST) && i_operand_done && !abort
		|=> idx_we_ff && (idx_ff == add16($past(i_index), ADDR_STEP)))
		else $error("post increment wrong");
	a_halt_bdm: assert property (take_op && (i_op == OP_HALT) && !abort
		|=> o_bdm_active)
		else $error("halt did not enter background");
endmodule : cas_seq

// File: testbench/cas_mem_model.sv
`timescale 1ns/1ps
// memory behind the system bus, read data answers in the cycle of the read strobe
module cas_mem_model (
	// clock
	input  wire logic        i_core_clk,
	// bus from the sequencer
	input  wire logic [15:0] i_addr,
	input  wire logic        i_rd,
	// read data back
	output logic      [7:0]  o_rdata
);
	// last byte handed out, used to scramble an idle bus
	logic [7:0] last_ff = 8'h00;
	// remember each byte that was read
	always_ff @(posedge i_core_clk) begin
		if (i_rd)
			last_ff <= o_rdata;
	end
	// content is a fixed hash of the address; an idle bus shows the inverse of the last byte
	always_comb begin
		if (i_rd)
			o_rdata = i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A;
		else
			o_rdata = ~last_ff;
	end
endmodule : cas_mem_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import cas_pkg::*;
	// one operand case: mode, bases, offset, expected address
	typedef struct {
		cas_mode_e   m;
		logic [15:0] ix, sp, off, ea;
	} cas_row_s;
	// inputs, all given a value at time zero
	logic i_core_clk = 0, i_reset = 1, i_wdog_reset = 0, i_reset_pin_n = 1, i_src_det_done = 0;
	logic i_debug_pin = 1, i_op_valid = 0, i_insn_boundary = 0, i_operand_done = 0, i_irq = 0;
	logic i_debug_enable_bit = 0, i_dbg_enter = 0, i_dbg_resume = 0, i_single_step_cmd = 0;
	logic i_tag_resume_cmd = 0, i_stop_min_clk = 0;
	cas_op_e     i_op = OP_EA;
	cas_mode_e   i_mode = MODE_ABS;
	logic [15:0] i_off = 0, i_pc = 0, i_index = 0, i_sp = 0, i_irq_vec = 0;
	logic [7:0]  i_acc = 0, i_flags = 0, i_bus_rdata;
	// outputs
	logic [15:0] o_bus_addr, o_ea, o_index_new, o_sp_new, o_pc_new;
	logic [7:0]  o_bus_wdata, o_flags_new, o_queue_byte;
	logic        o_bus_rd, o_bus_wr, o_ea_valid, o_index_we, o_sp_we, o_flags_we, o_pc_we, o_queue_we;
	logic        o_busy, o_irq_ack, o_cpu_clk_run, o_osc_keep, o_min_clk_run, o_bdm_active;
	// counters
	int          fails = 0;
	int          n_tests = 0;
	// operand cases, wrap and unsigned offsets included
	cas_row_s    rows[8] = '{
		'{MODE_ABS,     16'h0000, 16'h0000, 16'h0000, 16'h0000},
		'{MODE_PTR,     16'h1000, 16'h0000, 16'h0000, 16'h1000},
		'{MODE_PTR_PI,  16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF},
		'{MODE_OFF8,    16'h10F0, 16'h0000, 16'h12FF, 16'h11EF},
		'{MODE_OFF8_PI, 16'h2000, 16'h0000, 16'h0080, 16'h2080},
		'{MODE_OFF16,   16'hF000, 16'h0000, 16'h2000, 16'h1000},
		'{MODE_SP8,     16'h0000, 16'h00F0, 16'h0090, 16'h0180},
		'{MODE_SP16,    16'h0000, 16'h8000, 16'h9001, 16'h1001}
	};

	cas_seq DUT (.*);
	cas_mem_model mem_u (.i_core_clk(i_core_clk), .i_addr(o_bus_addr), .i_rd(o_bus_rd), .o_rdata(i_bus_rdata));

	// free running core clock
	always #5 i_core_clk = ~i_core_clk;

	// byte the memory holds at an address
	function automatic logic [7:0] mem(input logic [15:0] a);
		mem = a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : mem
	// step past edges, inputs then change just after
	task automatic tick(input int n = 1);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : tick
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// one request while idle
	task automatic issue(input cas_op_e op);
		i_op = op;
		i_op_valid = 1'b1;
		tick();
		i_op_valid = 1'b0;
	endtask : issue
	// one cycle pulse on a debug command: 0 enter, 1 resume, 2 step, 3 tag resume
	task automatic pulse(input int w);
		{i_dbg_enter, i_dbg_resume, i_single_step_cmd, i_tag_resume_cmd} = 4'b1000 >> w;
		tick();
		{i_dbg_enter, i_dbg_resume, i_single_step_cmd, i_tag_resume_cmd} = 4'b0000;
	endtask : pulse
	// vector pair, free cycle, three queue reads, new pc
	task automatic vec_walk(input logic [15:0] va);
		logic [15:0] v;
		for (int k = 0; k < 20 && o_bus_rd !== 1'b1; k++) tick();
		chk(o_bus_addr, va, "vector high address");
		v[15:8] = mem(va);
		tick();
		chk({o_bus_rd, o_bus_addr}, {1'b1, va + 16'h0001}, "vector low address");
		v[7:0] = mem(va + 16'h0001);
		tick();
		chk(o_bus_rd, 1'b0, "free cycle");
		for (int k = 0; k < 3; k++) begin
			tick();
			chk({o_bus_rd, o_bus_addr}, {1'b1, v + k[15:0]}, "queue fill");
		end
		tick();
		chk({o_pc_we, o_pc_new}, {1'b1, v}, "new pc");
		chk({o_queue_we, o_queue_byte, o_busy}, {1'b1, mem(v + 16'h0002), 1'b0}, "last queue byte");
	endtask : vec_walk
	// five pushes then mask set and stack pointer moved
	task automatic push_walk(input logic ack);
		logic [7:0] d[5];
		d = '{i_pc[7:0], i_pc[15:8], i_index[7:0], i_acc, i_flags};
		for (int k = 0; k < 20 && o_bus_wr !== 1'b1; k++) tick();
		chk(o_irq_ack, ack, "acknowledge");
		// the source goes away and its vector changes once the sequence has begun
		i_irq = 1'b0;
		i_insn_boundary = 1'b0;
		i_irq_vec = ~i_irq_vec;
		for (int k = 0; k < 5; k++) begin
			chk({o_bus_wr, o_bus_addr, o_bus_wdata}, {1'b1, i_sp - k[15:0], d[k]}, "push");
			tick();
		end
		chk({o_bus_wr, o_flags_we, o_flags_new, o_sp_we, o_sp_new},
			{1'b0, 1'b1, i_flags | 8'h08, 1'b1, i_sp - 16'h0005}, "mask and stack");
	endtask : push_walk
	// verdict
	task automatic results;
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// watchdog, the whole run needs well under a thousand cycles
	initial begin
		#20000;
		fails++;
		$display("wrong value at %0t: run did not finish", $time);
		results();
	end

	// main sequence
	initial begin
		logic [15:0] exp;
		tick(3);
		i_reset = 1'b0;
		tick(6);
		chk({o_bus_rd, o_busy}, 2'b01, "fetch before source check");
		i_src_det_done = 1'b1;
		vec_walk(RST_VEC_HI);
		// operand address table
		foreach (rows[r]) begin
			i_mode = rows[r].m;
			i_index = rows[r].ix;
			i_sp = rows[r].sp;
			i_off = rows[r].off;
			i_pc = 16'h1234;
			exp = (rows[r].m == MODE_ABS) ? {mem(16'h1234), mem(16'h1235)} : rows[r].ea;
			issue(OP_EA);
			for (int k = 0; k < 8 && o_ea_valid !== 1'b1; k++) tick();
			chk({o_ea_valid, o_ea}, {1'b1, exp}, "operand address");
			if (rows[r].m inside {MODE_PTR_PI, MODE_OFF8_PI}) begin
				i_operand_done = 1'b1;
				tick();
				i_operand_done = 1'b0;
				for (int k = 0; k < 4 && o_index_we !== 1'b1; k++) tick();
				chk({o_index_we, o_index_new}, {1'b1, rows[r].ix + 16'h0001}, "index step");
			end
			for (int k = 0; k < 8 && o_busy !== 1'b0; k++) tick();
			// let an edge pass with the request low before the next row
			tick();
		end
		// interrupt held off until the instruction boundary
		i_pc = 16'hA1B2;
		i_index = 16'hC3D4;
		i_sp = 16'h01FF;
		i_acc = 8'h5E;
		i_flags = 8'h00;
		i_irq_vec = 16'hFFF0;
		i_irq = 1'b1;
		tick(5);
		chk(o_busy, 1'b0, "taken inside instruction");
		i_insn_boundary = 1'b1;
		push_walk(1'b1);
		vec_walk(16'hFFF0);
		// masked interrupt waits, soft trap does not
		i_flags = 8'h08;
		i_irq = 1'b1;
		i_insn_boundary = 1'b1;
		tick(5);
		chk(o_busy, 1'b0, "masked interrupt taken");
		issue(OP_TRAP);
		push_walk(1'b0);
		vec_walk(TRAP_VEC_DEF);
		// wait, woken by an interrupt
		i_flags = 8'hFF;
		issue(OP_WAIT);
		for (int k = 0; k < 4 && o_flags_we !== 1'b1; k++) tick();
		chk({o_flags_we, o_flags_new, o_cpu_clk_run}, {1'b1, 8'hF7, 1'b0}, "wait entry");
		i_irq = 1'b1;
		for (int k = 0; k < 8 && o_busy !== 1'b0; k++) tick();
		chk({o_busy, o_cpu_clk_run}, 2'b01, "wake on interrupt");
		i_irq = 1'b0;
		// wait, woken by the debug enter command
		issue(OP_WAIT);
		tick();
		pulse(0);
		for (int k = 0; k < 8 && o_bdm_active !== 1'b1; k++) tick();
		chk({o_bdm_active, o_cpu_clk_run}, 2'b11, "debug wake from wait");
		// background left only by resume, step or tag resume
		for (int c = 0; c < 4; c++) begin
			if (c > 0)
				issue(OP_HALT);
			tick(3);
			chk(o_bdm_active, 1'b1, "background held");
			pulse(c % 3 + 1);
			for (int k = 0; k < 4 && o_busy !== 1'b0; k++) tick();
			chk({o_bdm_active, o_busy}, 2'b00, "resumed");
		end
		// stop without debug: enter is ignored, interrupt wakes
		i_stop_min_clk = 1'b1;
		issue(OP_STOP);
		tick();
		chk({o_cpu_clk_run, o_osc_keep, o_min_clk_run}, 3'b001, "stop clocks");
		pulse(0);
		tick(4);
		chk(o_bdm_active, 1'b0, "enter without oscillator");
		i_irq = 1'b1;
		for (int k = 0; k < 8 && o_busy !== 1'b0; k++) tick();
		chk({o_busy, o_cpu_clk_run}, 2'b01, "wake from stop");
		i_irq = 1'b0;
		// stop with debug enabled: oscillator kept, enter gives background
		i_debug_enable_bit = 1'b1;
		issue(OP_STOP);
		tick();
		chk({o_cpu_clk_run, o_osc_keep}, 2'b01, "oscillator kept");
		pulse(0);
		for (int k = 0; k < 8 && o_bdm_active !== 1'b1; k++) tick();
		chk({o_bdm_active, o_cpu_clk_run}, 2'b11, "debug wake from stop");
		tick();
		pulse(1);
		for (int k = 0; k < 4 && o_busy !== 1'b0; k++) tick();
		// reset in mid push, pin released last
		issue(OP_TRAP);
		for (int k = 0; k < 20 && o_bus_wr !== 1'b1; k++) tick();
		i_wdog_reset = 1'b1;
		i_reset_pin_n = 1'b0;
		tick();
		chk({o_bus_wr, o_bus_rd, o_busy}, 3'b001, "abort at once");
		i_wdog_reset = 1'b0;
		tick(8);
		chk(o_bus_rd, 1'b0, "fetch while pin low");
		i_reset_pin_n = 1'b1;
		vec_walk(RST_VEC_HI);
		// second reset with the debug pin low: background, oscillator kept
		i_debug_enable_bit = 1'b0;
		i_debug_pin = 1'b0;
		i_src_det_done = 1'b0;
		i_reset = 1'b1;
		tick(3);
		i_reset = 1'b0;
		tick(6);
		i_src_det_done = 1'b1;
		tick(2);
		chk({o_bdm_active, o_osc_keep, o_bus_rd}, 3'b110, "reset into background");
		pulse(1);
		chk({o_busy, o_osc_keep}, 2'b01, "resume keeps oscillator");
		results();
	end
endmodule : tb
